// file: design/fump_defs.vh
// Constants for the flash user-mode programming sequencer
`ifndef FUMP_DEFS_VH
`define FUMP_DEFS_VH
`define FUMP_RAM_BASE 10'h300
`define FUMP_RAM_LAST 10'h37F
`define FUMP_BLOCK_BYTES 8'h80
`define FUMP_ACP_FIRST 4'h5
`define FUMP_ACP_SECOND 4'hA
`define FUMP_CTL_PRG 0
`define FUMP_CTL_CLK_LO 3
`define FUMP_CTL_CLK_HI 4
`define FUMP_CTL_AMP 5
`define FUMP_CTL_RESET 8'hC6
`define FUMP_ADR_LO 3
`define FUMP_ADR_HI 12
`define FUMP_LOCK_MS 20
`define FUMP_CLK_KHZ 50000
`define FUMP_LOCK_CYC (`FUMP_LOCK_MS * `FUMP_CLK_KHZ)
`define FUMP_ERASE_CYC 1000
`endif

// file: design/fump_clkdiv.v
// Transfer clock enable generator with selectable divide ratio
`timescale 1ns/100ps
module fump_clkdiv (
   input wire clk_i,
   input wire rst_i,
   input wire run_i,
   input wire [1:0] sel_i,
   output reg tick_o
);
   reg [3:0] cnt_ff; // Divider count
   reg [3:0] lim; // Terminal count for selection

   // Select divide: 16, 8, 4, 2
   always @* begin
      case (sel_i)
         2'h0: lim = 4'hF;
         2'h1: lim = 4'h7;
         2'h2: lim = 4'h3;
         default: lim = 4'h1;
      endcase
   end

   // Free count while running, tick at terminal
   always @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_ff <= 4'h0;
         tick_o <= 1'b0;
      end else if (cnt_ff >= lim) begin
         cnt_ff <= 4'h0;
         tick_o <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
         tick_o <= 1'b0;
      end
   end
endmodule

// file: design/fump_sequencer.v
// Flash user-mode programming sequencer: unlock, hold, erase, copy, write
//
// How it works
// [R01] Software loads address shifted right by three; code expects a shift of four (block in bits 12..3 is flash address bits 16..7)
// [R02] Software writes n5 then nA to acceptor
// [R03] Program flag: one instruction, hold, program
// [R04] Copy 128 bytes from RAM 300..37F
// [R05] Interrupts deferred until programming completes
// [R06] External reset aborts programming immediately
// [R07] Software avoids programming its own block
// [R08] Programming locked about 20 ms after power-on
// [R09] Software sets 50 us STOP wake wait
// [R10] Supply-sense reset locks programming; ignored in STOP
// [R11] Acceptor set by n5,nA; cleared after programming
// [R12] Bits 0,3,4 need acceptor, no security
// [R13] Bits 3,4 select transfer clock, reset /16
// [R14] Address bits 3..12 hold block; others one
// [R15] Program flag self-clears; locked writes ignored
// [R16] Flash reads blocked during hold
`timescale 1ns/100ps
`include "fump_defs.vh"
module fump_sequencer #(
   parameter LOCK_CYC = `FUMP_LOCK_CYC,
   parameter ERASE_CYC = `FUMP_ERASE_CYC
) (
   input wire clk_i,
   input wire rst_i,
   input wire por_i,
   input wire supply_sense_i,
   input wire stop_osc_i,
   input wire security_i,
   input wire acp_wr_i,
   input wire ctl_wr_i,
   input wire adr_wr_i,
   input wire [15:0] wr_data_i,
   input wire instr_done_i,
   input wire irq_i,
   input wire flash_rd_i,
   input wire [7:0] ram_data_i,
   output reg [9:0] ram_addr_o,
   output reg ram_rd_o,
   output reg [16:0] flash_addr_o,
   output reg [7:0] flash_data_o,
   output reg flash_wr_o,
   output reg flash_erase_o,
   output wire cpu_hold_o,
   output wire irq_o,
   output wire flash_rd_ok_o,
   output wire [7:0] program_control_o,
   output wire [15:0] target_address_o,
   output wire acceptor_o,
   output wire lock_o
);
   localparam S_IDLE = 3'h0; // Waiting for program flag
   localparam S_ONE = 3'h1; // One further instruction
   localparam S_ERASE = 3'h2; // Block auto-erase
   localparam S_COPY = 3'h3; // Byte transfer
   localparam S_DONE = 3'h4; // Release hold

   reg [2:0] st_ff; // Sequencer state
   reg [2:0] nxt_st;
   reg acp_ff; // Acceptor flag
   reg acp_half_ff; // First unlock byte seen
   reg prg_ff; // Program start flag
   reg [1:0] fclk_ff; // Transfer clock select
   reg amp_ff; // Sense amplifier off
   reg [9:0] blk_ff; // Block number
   reg [7:0] idx_ff; // Byte index
   reg [31:0] lock_ff; // Programming lockout counter
   reg [31:0] era_ff; // Erase timer
   reg irq_pend_ff; // Deferred interrupt
   reg [1:0] ss_sync_ff; // Supply sense synchroniser
   reg [1:0] st_sync_ff; // Stop synchroniser
   reg rd_ph_ff; // RAM read issued, write next
   wire tick; // Transfer clock enable
   wire busy; // Hold active
   wire unlocked; // Locked bits writable

   // Synchronise pin inputs
   always @(posedge clk_i) begin
      ss_sync_ff <= {ss_sync_ff[0], supply_sense_i};
      st_sync_ff <= {st_sync_ff[0], stop_osc_i};
   end

   // Lockout after power-on or supply sense reset
   always @(posedge clk_i) begin
      if (por_i)
         lock_ff <= LOCK_CYC; // R08
      else if (ss_sync_ff[1] && !st_sync_ff[1])
         lock_ff <= LOCK_CYC; // R10
      else if (lock_ff != 32'h0)
         lock_ff <= lock_ff - 32'h1;
   end
   assign lock_o = (lock_ff != 32'h0);

   assign unlocked = acp_ff && !security_i; // R12
   assign busy = (st_ff != S_IDLE) && (st_ff != S_ONE);

   // Next state logic
   always @* begin
      nxt_st = st_ff;
      case (st_ff)
         S_IDLE: if (prg_ff && !lock_o) nxt_st = S_ONE;
         S_ONE: if (instr_done_i) nxt_st = S_ERASE; // R03
         S_ERASE: if (era_ff == 32'h0) nxt_st = S_COPY;
         S_COPY: if (tick && rd_ph_ff &&
            idx_ff == `FUMP_BLOCK_BYTES - 8'h1) nxt_st = S_DONE;
         S_DONE: nxt_st = S_IDLE;
         default: nxt_st = S_IDLE;
      endcase
   end

   // Registers and sequencing; external reset aborts at once
   always @(posedge clk_i) begin
      if (rst_i) begin // R06
         st_ff <= S_IDLE;
         acp_ff <= 1'b0;
         acp_half_ff <= 1'b0;
         prg_ff <= 1'b0;
         fclk_ff <= 2'h0; // R13
         amp_ff <= 1'b0;
         blk_ff <= 10'h0;
         idx_ff <= 8'h0;
         era_ff <= 32'h0;
         rd_ph_ff <= 1'b0;
         ram_rd_o <= 1'b0;
         ram_addr_o <= `FUMP_RAM_BASE;
         flash_wr_o <= 1'b0;
         flash_erase_o <= 1'b0;
         flash_addr_o <= 17'h0;
         flash_data_o <= 8'h0;
      end else begin
         st_ff <= nxt_st;
         ram_rd_o <= 1'b0;
         flash_wr_o <= 1'b0;
         flash_erase_o <= 1'b0;
         // Acceptor unlock sequence
         if (acp_wr_i && !busy) begin
            acp_half_ff <= (wr_data_i[3:0] == `FUMP_ACP_FIRST);
            if (acp_half_ff && wr_data_i[3:0] == `FUMP_ACP_SECOND)
               acp_ff <= 1'b1; // R11
         end else if (ctl_wr_i || adr_wr_i)
            acp_half_ff <= 1'b0;
         // Control writes; locked bits silently dropped
         if (ctl_wr_i && !busy) begin
            amp_ff <= wr_data_i[`FUMP_CTL_AMP];
            if (unlocked) begin // R15
               prg_ff <= wr_data_i[`FUMP_CTL_PRG];
               fclk_ff <= {wr_data_i[`FUMP_CTL_CLK_HI],
                  wr_data_i[`FUMP_CTL_CLK_LO]}; // R13
            end
         end
         if (adr_wr_i && !busy)
            blk_ff <= wr_data_i[`FUMP_ADR_HI:`FUMP_ADR_LO]; // R14
         case (st_ff)
            S_ONE: if (instr_done_i) begin
               era_ff <= ERASE_CYC;
               flash_erase_o <= 1'b1;
               flash_addr_o <= {blk_ff, 7'h00};
               idx_ff <= 8'h0;
               rd_ph_ff <= 1'b0;
            end
            S_ERASE: if (era_ff != 32'h0) era_ff <= era_ff - 32'h1;
            S_COPY: if (tick) begin // R04
               if (!rd_ph_ff) begin
                  ram_rd_o <= 1'b1;
                  ram_addr_o <= `FUMP_RAM_BASE + {2'h0, idx_ff};
                  rd_ph_ff <= 1'b1;
               end else begin
                  flash_wr_o <= 1'b1;
                  flash_data_o <= ram_data_i;
                  flash_addr_o <= {blk_ff, idx_ff[6:0]};
                  idx_ff <= idx_ff + 8'h1;
                  rd_ph_ff <= 1'b0;
               end
            end
            S_DONE: begin
               prg_ff <= 1'b0; // R15
               acp_ff <= 1'b0; // R11
            end
            default: ;
         endcase
      end
   end

   // Interrupt deferral while held
   always @(posedge clk_i) begin
      if (rst_i)
         irq_pend_ff <= 1'b0;
      else if (busy && irq_i)
         irq_pend_ff <= 1'b1; // R05
      else if (!busy)
         irq_pend_ff <= 1'b0;
   end
   assign irq_o = !busy && (irq_i || irq_pend_ff); // R05

   assign cpu_hold_o = busy; // R03
   assign flash_rd_ok_o = flash_rd_i && !busy; // R16
   assign program_control_o = {2'h3, amp_ff, fclk_ff, 2'h3, prg_ff};
   assign target_address_o = {3'h7, blk_ff, 3'h7}; // R14
   assign acceptor_o = acp_ff;

   fump_clkdiv u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(st_ff == S_COPY),
      .sel_i(fclk_ff),
      .tick_o(tick)
   );
endmodule

// file: tb/fump_monitor.sv
// Assertion checker for the flash programming sequencer
`timescale 1ns/100ps
module fump_monitor (
   input wire clk_i,
   input wire rst_i,
   input wire irq_i,
   input wire flash_rd_i,
   input wire instr_done_i,
   input wire [9:0] ram_addr_o,
   input wire ram_rd_o,
   input wire flash_wr_o,
   input wire flash_erase_o,
   input wire cpu_hold_o,
   input wire irq_o,
   input wire flash_rd_ok_o,
   input wire [7:0] program_control_o,
   input wire [15:0] target_address_o,
   input wire acceptor_o,
   input wire lock_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_irq_held: assert property (cpu_hold_o |-> !irq_o)
      else $error("interrupt passed during hold");
   a_irq_free: assert property (!cpu_hold_o && irq_i |-> irq_o)
      else $error("interrupt lost outside hold");
   a_read_blocked: assert property (cpu_hold_o |-> !flash_rd_ok_o)
      else $error("flash read served in hold");
   a_ctl_reset: assert property ($fell(rst_i) |-> program_control_o == 8'hC6)
      else $error("control reset value wrong");
   a_done_clears: assert property ($fell(cpu_hold_o) |->
      !program_control_o[0] && !acceptor_o)
      else $error("flag or acceptor not cleared");
   a_hold_start: assert property ($rose(cpu_hold_o) |-> $past(instr_done_i))
      else $error("hold without instruction end");
   a_ram_window: assert property (ram_rd_o |->
      ram_addr_o >= 10'h300 && ram_addr_o <= 10'h37F)
      else $error("ram read outside window");
   a_write_hold: assert property (flash_wr_o || flash_erase_o |-> cpu_hold_o)
      else $error("flash access outside hold");
   a_addr_ones: assert property (target_address_o[15:13] == 3'h7 &&
      target_address_o[2:0] == 3'h7)
      else $error("unused address bits not one");
   a_lock_stays: assert property (lock_o && !cpu_hold_o |=> !cpu_hold_o)
      else $error("programming while locked");
endmodule
bind fump_sequencer fump_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .irq_i(irq_i), .flash_rd_i(flash_rd_i), .instr_done_i(instr_done_i),
   .ram_addr_o(ram_addr_o), .ram_rd_o(ram_rd_o), .flash_wr_o(flash_wr_o),
   .flash_erase_o(flash_erase_o), .cpu_hold_o(cpu_hold_o), .irq_o(irq_o),
   .flash_rd_ok_o(flash_rd_ok_o), .program_control_o(program_control_o),
   .target_address_o(target_address_o), .acceptor_o(acceptor_o),
   .lock_o(lock_o));

// file: tb/fump_tb.sv
// Directed testbench for the flash programming sequencer
`timescale 1ns/100ps
module testbench;
   logic clk_i = 0, rst_i = 1, por_i = 1, supply_sense_i = 0, stop_osc_i = 0;
   logic security_i = 0, acp_wr_i = 0, ctl_wr_i = 0, adr_wr_i = 0;
   logic [15:0] wr_data_i = 16'h0000;
   logic instr_done_i = 0, irq_i = 0, flash_rd_i = 0;
   wire [7:0] ram_data_i, flash_data_o, program_control_o;
   wire [9:0] ram_addr_o;
   wire [16:0] flash_addr_o;
   wire [15:0] target_address_o;
   wire ram_rd_o, flash_wr_o, flash_erase_o, cpu_hold_o, irq_o;
   wire flash_rd_ok_o, acceptor_o, lock_o;
   int miscompares = 0, total_checks = 0;
   // RAM model: each byte derived from its address
   assign ram_data_i = ram_addr_o[7:0] ^ 8'hA5;
   always #10 clk_i = ~clk_i;
   fump_sequencer #(.LOCK_CYC(50), .ERASE_CYC(20)) dut (.clk_i(clk_i),
      .rst_i(rst_i), .por_i(por_i), .supply_sense_i(supply_sense_i),
      .stop_osc_i(stop_osc_i), .security_i(security_i), .acp_wr_i(acp_wr_i),
      .ctl_wr_i(ctl_wr_i), .adr_wr_i(adr_wr_i), .wr_data_i(wr_data_i),
      .instr_done_i(instr_done_i), .irq_i(irq_i), .flash_rd_i(flash_rd_i),
      .ram_data_i(ram_data_i), .ram_addr_o(ram_addr_o), .ram_rd_o(ram_rd_o),
      .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o),
      .flash_wr_o(flash_wr_o), .flash_erase_o(flash_erase_o),
      .cpu_hold_o(cpu_hold_o), .irq_o(irq_o), .flash_rd_ok_o(flash_rd_ok_o),
      .program_control_o(program_control_o),
      .target_address_o(target_address_o), .acceptor_o(acceptor_o),
      .lock_o(lock_o));
   // Compare one value and count it
   task chk(input logic [16:0] got, input logic [16:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // One register write: 0 acceptor, 1 control, 2 address
   task wr(input int k, input logic [15:0] d);
      @(negedge clk_i);
      {adr_wr_i, ctl_wr_i, acp_wr_i} = 3'b001 << k;
      wr_data_i = d;
      @(negedge clk_i);
      {adr_wr_i, ctl_wr_i, acp_wr_i} = 3'b000;
   endtask
   // Lockout after power-on and after supply sense
   task t_lock;
      chk(program_control_o, 8'hC6);
      chk(lock_o, 1);
      repeat (60) @(negedge clk_i);
      chk(lock_o, 0);
      {stop_osc_i, supply_sense_i} = 2'b11;
      repeat (6) @(negedge clk_i);
      chk(lock_o, 0);
      {stop_osc_i, supply_sense_i} = 2'b01;
      repeat (6) @(negedge clk_i);
      chk(lock_o, 1);
      supply_sense_i = 0;
      repeat (60) @(negedge clk_i);
      chk(lock_o, 0);
      $display("t_lock done");
   endtask
   // Locked control bits, free bit 5, security
   task t_locked;
      wr(1, 16'h0019);
      chk(program_control_o, 8'hC6);
      wr(1, 16'h0020);
      chk(program_control_o, 8'hE6);
      wr(1, 16'h0000);
      wr(0, 16'h00F5);
      wr(0, 16'h00FA);
      chk(acceptor_o, 1);
      security_i = 1;
      wr(1, 16'h0011);
      chk(program_control_o, 8'hC6);
      security_i = 0;
      $display("t_locked done");
   endtask
   // Full block program with deferred interrupt and blocked reads
   task t_program;
      int i, n;
      logic h;
      wr(2, 16'h0550);
      chk(target_address_o, 16'hE557);
      wr(1, 16'h0011);
      chk(program_control_o, 8'hD7);
      {irq_i, flash_rd_i} = 2'b11;
      h = 0;
      n = 0;
      for (i = 0; i < 20000 && !(h && !cpu_hold_o); i++) begin
         @(negedge clk_i);
         instr_done_i = (i == 2);
         if (cpu_hold_o === 1'b1) h = 1;
         if (flash_erase_o === 1'b1) chk(flash_addr_o, 17'h05500);
         if (flash_wr_o === 1'b1) begin
            chk(flash_addr_o, 17'h05500 + n);
            chk(flash_data_o, n[7:0] ^ 8'hA5);
            if (n == 64) chk({irq_o, flash_rd_ok_o}, 0);
            if (n == 64) irq_i = 0;
            n++;
         end
      end
      chk(n, 128);
      chk({program_control_o[0], acceptor_o}, 0);
      chk({irq_o, flash_rd_ok_o}, 3);
      $display("t_program done");
   endtask
   // External reset in mid-programming aborts the operation
   task t_abort;
      wr(2, 16'h0560);
      wr(0, 16'h0005);
      wr(0, 16'h000A);
      wr(1, 16'h0019);
      chk(program_control_o, 8'hDF);
      // Flag set last edge; wait for the one-instruction state
      @(negedge clk_i);
      instr_done_i = 1;
      @(negedge clk_i);
      instr_done_i = 0;
      repeat (10) @(negedge clk_i);
      chk(cpu_hold_o, 1);
      rst_i = 1;
      @(negedge clk_i);
      rst_i = 0;
      @(negedge clk_i);
      chk({cpu_hold_o, program_control_o}, 9'h0C6);
      $display("t_abort done");
   endtask
   // Verdict and end of run
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #(20 * 30000);
      miscompares++;
      stop_test;
   end
   // Main sequence
   initial begin
      repeat (16) @(negedge clk_i);
      {rst_i, por_i} = 2'b00;
      t_lock;
      t_locked;
      t_program;
      t_abort;
      stop_test;
   end
endmodule
